// file: pkg/e1_sig_pkg.sv
// constants and carrier types for the e1 signaling and channel monitor block
package e1_sig_pkg;
    localparam logic [7:0] ADDR_ERR_HI = 8'h06;
    localparam logic [7:0] ADDR_ERR_LO = 8'h07;
    localparam logic [7:0] ADDR_TX_SEL = 8'h14;
    localparam logic [7:0] ADDR_RX_SEL = 8'h15;
    localparam logic [7:0] ADDR_TX_SNAP = 8'h22;
    localparam logic [7:0] ADDR_RX_SNAP = 8'h2a;
    localparam logic [7:0] ADDR_SIG_FIRST = 8'h30;
    localparam logic [7:0] ADDR_SIG_LAST = 8'h3f;
    localparam int SEL_MSB = 4;
    localparam int SEL_LSB = 0;
    localparam logic [4:0] SIG_SLOT = 5'h10;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam int CLK_MHZ = 125;
    localparam int ONE_SEC_S = 1;
    localparam real FAST_INTERVAL_MS = 62.5;
    localparam int ONE_SEC_CYC = ONE_SEC_S * 1000000 * CLK_MHZ;
    localparam int FAST_CYC = int'($floor(FAST_INTERVAL_MS * 1000.0 * CLK_MHZ));
    localparam int FIFO_W = 12;
    localparam int FIFO_D = 32;

    typedef struct packed {
        logic bit_en;
        logic data;
        logic [4:0] slot;
        logic [2:0] bitn;
        logic [3:0] frame;
        logic mf_start;
    } line_slot_type;

    typedef struct packed {
        logic fas_err;
        logic los;
        logic fas_search;
        logic mf_search;
    } rx_sync_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } host_rsp_type;

    typedef struct packed {
        logic [3:0] idx;
        logic [7:0] data;
    } sig_write_type;
endpackage

// file: hw/e1_sig_monitor.sv
// signaling buffers, alignment-word error counter and channel monitors
`timescale 1ns/1ps
`default_nettype none

module sig_fifo #(
    parameter int W = 12,
    parameter int D = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output var logic in_ready,
    output var logic out_valid,
    output var logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wptr_q, rptr_q;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign out_valid = cnt_q != '0;
    assign out_data = mem[rptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b0;
        end else begin
            wptr_q <= push ? AW'(wptr_q + 1'b1) : wptr_q;
            rptr_q <= pop ? AW'(rptr_q + 1'b1) : rptr_q;
            cnt_q <= cnt_d;
            in_ready <= cnt_d < DEPTH_C;
        end
    end
endmodule

module e1_sig_monitor
    import e1_sig_pkg::*;
#(
    parameter int SEC_CYC = ONE_SEC_CYC,
    parameter int FAST_INT_CYC = FAST_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire e1_sig_pkg::host_req_type host_req,
    output var e1_sig_pkg::host_rsp_type host_rsp,
    output var logic host_ready,
    input wire e1_sig_pkg::line_slot_type rx_line,
    input wire e1_sig_pkg::rx_sync_type rx_sync,
    input wire e1_sig_pkg::line_slot_type tx_line,
    output var e1_sig_pkg::line_slot_type tx_out,
    input wire logic sig_insert_en,
    input wire logic sig_readback,
    input wire logic fast_interval,
    input wire logic rx_sig_new_clr,
    input wire logic tx_mf_clr,
    output var logic rx_sig_new,
    output var logic tx_mf_flag
);
    import e1_sig_pkg::*;

    function automatic logic is_sig(input logic [7:0] a);
        return a >= ADDR_SIG_FIRST && a <= ADDR_SIG_LAST;
    endfunction

    function automatic logic [3:0] sig_index(input logic [7:0] a);
        return a[3:0];
    endfunction

    logic [15:0] err_run_q, err_vis_q;
    logic [31:0] tmr_q;
    logic tick, err_ok;
    logic [7:0] tx_sel_q, rx_sel_q;
    logic [15:0][7:0] rx_stage_q, rx_buf_q, tx_buf_q, tx_shift_q;
    logic [6:0] rx_shift_q;
    logic [1:0][7:0] snap_q;
    logic [1:0][6:0] mon_shift_q;
    line_slot_type mon_src [2];
    logic [4:0] mon_sel [2];
    logic fifo_out_valid, fifo_out_ready, fifo_in_valid;
    sig_write_type fifo_in, fifo_out;
    logic [7:0] rd_data;

    // interval timer for latching the visible count; at or past the limit it restarts,
    // so switching to the short interval mid-count cannot leave it running to wrap
    assign tick = tmr_q >= (fast_interval ? 32'(FAST_INT_CYC - 1) : 32'(SEC_CYC - 1));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= tick ? '0 : tmr_q + 32'h1;
        end
    end

    // alignment-word error counter
    assign err_ok = rx_sync.fas_err && !rx_sync.los && !rx_sync.fas_search && !rx_sync.mf_search;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            err_run_q <= COUNT_RESET;
            err_vis_q <= COUNT_RESET;
        end else if (tick) begin
            err_vis_q <= err_run_q;
            err_run_q <= {15'h0, err_ok};
        end else if (err_ok && err_run_q != COUNT_MAX) begin
            err_run_q <= err_run_q + 16'h1;
        end
    end

    // receive signaling capture
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_shift_q <= '0;
            rx_stage_q <= '0;
            rx_buf_q <= '0;
        end else begin
            if (rx_line.bit_en && rx_line.slot == SIG_SLOT) begin
                if (rx_line.bitn == LAST_BIT) begin
                    rx_stage_q[rx_line.frame] <= {rx_shift_q, rx_line.data};
                end else begin
                    rx_shift_q <= {rx_shift_q[5:0], rx_line.data};
                end
            end
            if (rx_line.mf_start) begin
                rx_buf_q <= rx_stage_q;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_sig_new <= 1'b0;
            tx_mf_flag <= 1'b0;
        end else begin
            rx_sig_new <= rx_line.mf_start || (rx_sig_new && !rx_sig_new_clr);
            tx_mf_flag <= tx_line.mf_start || (tx_mf_flag && !tx_mf_clr);
        end
    end

    // host signaling writes queue here; draining pauses on the load cycle
    assign fifo_in_valid = host_req.wr && is_sig(host_req.addr);
    assign fifo_in.idx = sig_index(host_req.addr);
    assign fifo_in.data = host_req.wdata;
    assign fifo_out_ready = !tx_line.mf_start;

    sig_fifo #(
        .W(FIFO_W),
        .D(FIFO_D)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(fifo_in_valid),
        .in_data(fifo_in),
        .in_ready(host_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out),
        .out_ready(fifo_out_ready)
    );

    // transmit buffer, shifter and insertion
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_buf_q <= '0;
            tx_shift_q <= '0;
        end else begin
            if (fifo_out_valid && fifo_out_ready) begin
                tx_buf_q[fifo_out.idx] <= fifo_out.data;
            end
            if (tx_line.mf_start) begin
                tx_shift_q <= tx_buf_q;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_out <= '0;
        end else begin
            tx_out <= tx_line;
            if (sig_insert_en && tx_line.slot == SIG_SLOT) begin
                tx_out.data <= tx_shift_q[tx_line.frame][LAST_BIT - tx_line.bitn];
            end
        end
    end

    // channel selects
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_sel_q <= SEL_RESET;
            rx_sel_q <= SEL_RESET;
        end else if (host_req.wr) begin
            if (host_req.addr == ADDR_TX_SEL) begin
                tx_sel_q <= host_req.wdata;
            end
            if (host_req.addr == ADDR_RX_SEL) begin
                rx_sel_q <= host_req.wdata;
            end
        end
    end

    // channel monitors, one per direction
    assign mon_src[0] = tx_out;
    assign mon_src[1] = rx_line;
    assign mon_sel[0] = tx_sel_q[SEL_MSB:SEL_LSB];
    assign mon_sel[1] = rx_sel_q[SEL_MSB:SEL_LSB];

    for (genvar i = 0; i < 2; i++) begin : g_mon
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                mon_shift_q[i] <= '0;
                snap_q[i] <= BYTE_RESET;
            end else if (mon_src[i].bit_en && mon_src[i].slot == mon_sel[i]) begin
                if (mon_src[i].bitn == LAST_BIT) begin
                    snap_q[i] <= {mon_shift_q[i], mon_src[i].data};
                end else begin
                    mon_shift_q[i] <= {mon_shift_q[i][5:0], mon_src[i].data};
                end
            end
        end
    end

    // register reads
    always_comb begin
        rd_data = BYTE_RESET;
        if (is_sig(host_req.addr)) begin
            if (sig_readback) begin
                rd_data = tx_buf_q[sig_index(host_req.addr)];
            end else begin
                rd_data = rx_buf_q[sig_index(host_req.addr)];
            end
        end else begin
            case (host_req.addr)
                ADDR_ERR_HI: rd_data = err_vis_q[15:8];
                ADDR_ERR_LO: rd_data = err_vis_q[7:0];
                ADDR_TX_SEL: rd_data = tx_sel_q;
                ADDR_RX_SEL: rd_data = rx_sel_q;
                ADDR_TX_SNAP: rd_data = snap_q[0];
                ADDR_RX_SNAP: rd_data = snap_q[1];
                default: rd_data = BYTE_RESET;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            host_rsp <= '0;
        end else begin
            host_rsp.valid <= host_req.rd;
            host_rsp.data <= host_req.rd ? rd_data : host_rsp.data;
        end
    end

    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_err_count;
        err_ok && !tick && err_run_q != COUNT_MAX |=> err_run_q == $past(err_run_q) + 16'h1;
    endproperty
    a_err_count: assert property (p_err_count) else $error("error count did not step");

    property p_err_los;
        rx_sync.los && !tick |=> err_run_q == $past(err_run_q);
    endproperty
    a_err_los: assert property (p_err_los) else $error("count moved during signal loss");

    property p_err_search;
        (rx_sync.fas_search || rx_sync.mf_search) && !tick |=> $stable(err_run_q);
    endproperty
    a_err_search: assert property (p_err_search) else $error("count moved during search");

    property p_latch;
        tick |=> err_vis_q == $past(err_run_q) && err_run_q <= 16'h1;
    endproperty
    a_latch: assert property (p_latch) else $error("visible count not latched");

    property p_rx_read;
        host_req.rd && is_sig(host_req.addr) && !sig_readback && !rx_line.mf_start
            |=> host_rsp.valid && host_rsp.data == rx_buf_q[$past(sig_index(host_req.addr))];
    endproperty
    a_rx_read: assert property (p_rx_read) else $error("signaling read wrong");

    property p_rx_hold;
        !rx_line.mf_start |=> $stable(rx_buf_q) ##1 1'b1;
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("receive buffer moved off boundary");

    property p_rx_new;
        rx_line.mf_start |=> rx_sig_new && rx_buf_q == $past(rx_stage_q);
    endproperty
    a_rx_new: assert property (p_rx_new) else $error("new signaling not flagged");

    property p_tx_load;
        tx_line.mf_start |=> tx_shift_q == $past(tx_buf_q) && tx_mf_flag;
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("transmit shifter not loaded");

    property p_no_insert;
        !sig_insert_en |=> tx_out.data == $past(tx_line.data);
    endproperty
    a_no_insert: assert property (p_no_insert) else $error("insertion while disabled");

    property p_snap_whole;
        !(tx_out.bit_en && tx_out.slot == mon_sel[0] && tx_out.bitn == LAST_BIT) |=> $stable(snap_q[0]);
    endproperty
    a_snap_whole: assert property (p_snap_whole) else $error("partial monitor byte");

    property p_snap_rx_whole;
        !(rx_line.bit_en && rx_line.slot == mon_sel[1] && rx_line.bitn == LAST_BIT) |=> $stable(snap_q[1]);
    endproperty
    a_snap_rx_whole: assert property (p_snap_rx_whole) else $error("partial receive monitor byte");

    property p_insert;
        sig_insert_en && tx_line.slot == SIG_SLOT
            |=> tx_out.data == $past(tx_shift_q[tx_line.frame][LAST_BIT - tx_line.bitn]);
    endproperty
    a_insert: assert property (p_insert) else $error("signaling bit not inserted");

    property p_rx_clr;
        rx_sig_new_clr && !rx_line.mf_start |=> !rx_sig_new;
    endproperty
    a_rx_clr: assert property (p_rx_clr) else $error("receive flag not cleared");

    property p_tx_clr;
        tx_mf_clr && !tx_line.mf_start |=> !tx_mf_flag;
    endproperty
    a_tx_clr: assert property (p_tx_clr) else $error("transmit boundary flag not cleared");

    c_rx_update: cover property (rx_line.mf_start ##1 rx_sig_new);
    c_tx_insert: cover property (sig_insert_en && tx_line.slot == SIG_SLOT && tx_line.bit_en);
    c_fifo_full: cover property (!host_ready);
    c_latch: cover property (tick && err_run_q != COUNT_RESET);
endmodule

`default_nettype wire

// file: verif/e1_far_end.sv
// far-end e1 line model making receive and transmit bit streams
`timescale 1ns/1ps
`default_nettype none
module e1_far_end (
    input wire logic clk,
    input wire logic nrst,
    output var e1_sig_pkg::line_slot_type rx_line,
    output var e1_sig_pkg::line_slot_type tx_line
);
    import e1_sig_pkg::*;
    logic [2:0] bit_q;
    logic [4:0] slot_q;
    logic [3:0] frame_q;
    logic [7:0] byte_v;
    // free-running frame timing, one line bit per clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bit_q <= 3'h0;
            slot_q <= 5'h00;
            frame_q <= 4'h0;
        end else begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == LAST_BIT) begin
                slot_q <= slot_q + 5'h01;
                if (slot_q == 5'h1f) begin
                    frame_q <= frame_q + 4'h1;
                end
            end
        end
    end
    // slot sixteen carries frame-indexed signaling, other slots a slot-numbered byte
    always_comb begin
        byte_v = (slot_q == SIG_SLOT) ? {frame_q, ~frame_q} : {slot_q, 3'h3};
        rx_line.bit_en = nrst;
        rx_line.data = byte_v[LAST_BIT - bit_q];
        rx_line.slot = slot_q;
        rx_line.bitn = bit_q;
        rx_line.frame = frame_q;
        rx_line.mf_start = nrst && (slot_q == 5'h00) && (bit_q == 3'h0) && (frame_q == 4'h0);
        tx_line = rx_line;
        tx_line.data = ~rx_line.data;
    end
endmodule
`default_nettype wire

// file: verif/e1_sig_monitor_tb.sv
// self-checking bench for the e1 signaling and channel monitor block
`timescale 1ns/1ps
`default_nettype none
module e1_sig_monitor_tb;
    import e1_sig_pkg::*;
    localparam int SEC = 200;
    localparam int FAST = 50;
    logic clk, nrst, host_ready, sig_insert_en, sig_readback, fast_interval;
    logic rx_sig_new_clr, tx_mf_clr, rx_sig_new, tx_mf_flag;
    host_req_type host_req;
    host_rsp_type host_rsp;
    line_slot_type rx_line, tx_line, tx_out;
    rx_sync_type rx_sync;
    int miscompares, compares, cycles;
    e1_sig_monitor #(.SEC_CYC(SEC), .FAST_INT_CYC(FAST)) uut (.clk(clk), .nrst(nrst), .host_req(host_req),
        .host_rsp(host_rsp), .host_ready(host_ready), .rx_line(rx_line), .rx_sync(rx_sync), .tx_line(tx_line),
        .tx_out(tx_out), .sig_insert_en(sig_insert_en), .sig_readback(sig_readback),
        .fast_interval(fast_interval), .rx_sig_new_clr(rx_sig_new_clr), .tx_mf_clr(tx_mf_clr),
        .rx_sig_new(rx_sig_new), .tx_mf_flag(tx_mf_flag));
    e1_far_end far (.clk(clk), .nrst(nrst), .rx_line(rx_line), .tx_line(tx_line));
    task automatic report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        while (host_ready !== 1'b1) @(posedge clk);
        host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        host_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk);
        host_req.rd <= 1'b0;
        @(posedge clk);
        check8("read valid", 8'h01, {7'h0, host_rsp.valid});
        d = host_rsp.data;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check8(what, exp, d);
    endtask
    // clear a flag, check it dropped, then wait for the next boundary to set it
    task automatic wait_flag(input logic tx);
        @(posedge clk);
        if (tx) tx_mf_clr <= 1'b1;
        else rx_sig_new_clr <= 1'b1;
        @(posedge clk);
        tx_mf_clr <= 1'b0;
        rx_sig_new_clr <= 1'b0;
        @(posedge clk);
        check8("flag cleared", 8'h00, {7'h0, tx ? tx_mf_flag : rx_sig_new});
        while ((tx ? tx_mf_flag : rx_sig_new) !== 1'b1) @(posedge clk);
    endtask
    // four counted errors, then four under signal loss and four during searches
    task automatic fas_burst;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            rx_sync <= '{fas_err: 1'b1, los: i inside {[4:7]}, fas_search: i inside {8, 9}, mf_search: i > 9};
        end
        @(posedge clk);
        rx_sync <= '0;
    endtask
    // two reads one interval apart cover the burst whatever the latch phase
    task automatic err_chk(input int gap, input logic [7:0] exp);
        logic [7:0] a;
        logic [7:0] b;
        rd(ADDR_ERR_LO, a);
        repeat (gap - 3) @(posedge clk);
        rd(ADDR_ERR_LO, b);
        check8("error count", exp, a + b);
        rdchk("error count high", ADDR_ERR_HI, 8'h00);
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        nrst = 1'b0;
        host_req = '0;
        rx_sync = '0;
        sig_insert_en = 1'b0;
        sig_readback = 1'b0;
        fast_interval = 1'b0;
        rx_sig_new_clr = 1'b0;
        tx_mf_clr = 1'b0;
        miscompares = 0;
        compares = 0;
        cycles = 0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        check8("host ready", 8'h01, {7'h0, host_ready});
        rdchk("tx select reset", ADDR_TX_SEL, SEL_RESET);
        rdchk("rx select reset", ADDR_RX_SEL, SEL_RESET);
        rdchk("unmapped read", 8'h40, 8'h00);
        wr(ADDR_TX_SEL, 8'h09);
        wr(ADDR_RX_SEL, 8'h06);
        wr(ADDR_ERR_LO, 8'h55);
        rdchk("tx select", ADDR_TX_SEL, 8'h09);
        rdchk("rx select", ADDR_RX_SEL, 8'h06);
        fas_burst();
        err_chk(SEC, 8'h04);
        fast_interval <= 1'b1;
        repeat (3 * FAST) @(posedge clk);
        fas_burst();
        err_chk(FAST, 8'h04);
        wait_flag(1'b0);
        wait_flag(1'b0);
        for (int i = 0; i < 16; i++) begin
            rdchk("rx signaling", ADDR_SIG_FIRST + 8'(i), {i[3:0], ~i[3:0]});
        end
        rdchk("rx snapshot", ADDR_RX_SNAP, 8'h33);
        rdchk("tx snapshot", ADDR_TX_SNAP, 8'hb4);
        for (int i = 0; i < 16; i++) begin
            wr(ADDR_SIG_FIRST + 8'(i), (i == 0) ? 8'h0b : 8'ha5);
        end
        sig_readback <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            rdchk("tx readback", ADDR_SIG_FIRST + 8'(i), (i == 0) ? 8'h0b : 8'ha5);
        end
        sig_readback <= 1'b0;
        rdchk("rx signaling after write", ADDR_SIG_FIRST + 8'h03, 8'h3c);
        wr(ADDR_TX_SEL, 8'h10);
        wait_flag(1'b1);
        rdchk("tx slot 16 not inserted", ADDR_TX_SNAP, 8'h0f);
        sig_insert_en <= 1'b1;
        wait_flag(1'b1);
        wait_flag(1'b1);
        rdchk("tx slot 16 inserted", ADDR_TX_SNAP, 8'ha5);
        report_and_stop();
    end
endmodule
`default_nettype wire
